// ---- rtl/spc_pkg.sv ----
// Constants for the switch source, multipurpose pin and pulse channel register group
package spc_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_HIGH_SIDE_SOURCE_B = 7'h15;
    localparam logic [ADDR_W-1:0] ADDR_MULTIPURPOSE_PIN_CONFIG = 7'h17;
    localparam logic [ADDR_W-1:0] ADDR_PULSE_DUTY_ONE = 7'h18;
    localparam logic [ADDR_W-1:0] ADDR_PULSE_DUTY_TWO = 7'h19;
    localparam logic [ADDR_W-1:0] ADDR_PULSE_FREQUENCY_SELECT = 7'h1c;
    localparam logic [ADDR_W-1:0] ADDR_HOST_SCRATCH_BYTE = 7'h1e;
    localparam logic [DATA_W-1:0] RESET_VALUE = 8'h00;
    localparam logic [DATA_W-1:0] SOURCE_WRITE_MASK = 8'h77;
    localparam logic [DATA_W-1:0] FREQ_WRITE_MASK = 8'h05;
    localparam int SRC_W = 3;
    localparam int SRC_FOUR_LSB = 4;
    localparam int SRC_THREE_LSB = 0;
    localparam int PIN_ONE_LSB = 0;
    localparam int PIN_TWO_LSB = 3;
    localparam int FAIL_DUTY_LSB = 6;
    localparam int FREQ_ONE_BIT = 0;
    localparam int FREQ_TWO_BIT = 2;
    localparam logic [SRC_W-1:0] SRC_OFF = 3'h0;
    localparam logic [SRC_W-1:0] SRC_ON = 3'h1;
    localparam logic [SRC_W-1:0] SRC_TIMER_ONE = 3'h2;
    localparam logic [SRC_W-1:0] SRC_TIMER_TWO = 3'h3;
    localparam logic [SRC_W-1:0] SRC_PULSE_ONE = 3'h4;
    localparam logic [SRC_W-1:0] SRC_PULSE_TWO = 3'h5;
    localparam logic [SRC_W-1:0] PIN_OFF = 3'h4;
    localparam logic [SRC_W-1:0] PIN_WAKE = 3'h5;
    localparam logic [SRC_W-1:0] PIN_LOW_SIDE = 3'h6;
    localparam logic [SRC_W-1:0] PIN_HIGH_SIDE = 3'h7;
    localparam logic [1:0] FAIL_DUTY_20 = 2'h0;
    localparam logic [1:0] FAIL_DUTY_10 = 2'h1;
    localparam logic [1:0] FAIL_DUTY_5 = 2'h2;
    localparam logic [1:0] FAIL_DUTY_2P5 = 2'h3;
    localparam int CLK_HZ = 10000000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int PULSE_STEPS = 255;
    localparam int PULSE_SLOW_HZ = 200;
    localparam int PULSE_FAST_HZ = 400;
    localparam int PRESCALE_SLOW = CLK_HZ / (PULSE_SLOW_HZ * PULSE_STEPS);
    localparam int PRESCALE_FAST = CLK_HZ / (PULSE_FAST_HZ * PULSE_STEPS);
    localparam int PRESCALE_W = 8;
    localparam int WAKE_FILTER_NS = 16000;
    localparam int WAKE_FILTER_CYC = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CNT_W = 8;
endpackage

// ---- rtl/spc_pulse_channel.sv ----
// One pulse-width channel: prescaler plus 255-step period counter
`timescale 1ns/10ps
`default_nettype none
module spc_pulse_channel #(
    parameter int STEPS = spc_pkg::PULSE_STEPS,
    parameter int PRE_SLOW = spc_pkg::PRESCALE_SLOW,
    parameter int PRE_FAST = spc_pkg::PRESCALE_FAST
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic [spc_pkg::DATA_W-1:0] duty_i,
    input wire logic fast_i,
    output logic pulse_o
);
    import spc_pkg::*;
    logic [PRESCALE_W-1:0] pre_q, pre_d, pre_last;
    logic [DATA_W-1:0] step_q, step_d;
    logic pulse_d;

    always_comb begin
        pre_last = fast_i ? PRESCALE_W'(PRE_FAST - 1) : PRESCALE_W'(PRE_SLOW - 1);
        pre_d = pre_q;
        step_d = step_q;
        pulse_d = pulse_o;
        if (en_i) begin
            // Compare with >= so a frequency change mid-step cannot overrun
            if (pre_q >= pre_last) begin
                pre_d = '0;
                step_d = (step_q >= DATA_W'(STEPS - 1)) ? '0 : step_q + 8'h01;
            end else begin
                pre_d = pre_q + PRESCALE_W'(1);
            end
            // Step never reaches 255, so full code stays on and zero stays off
            pulse_d = step_q < duty_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pre_q <= '0;
            step_q <= '0;
            pulse_o <= 1'b0;
        end else begin
            pre_q <= pre_d;
            step_q <= step_d;
            pulse_o <= pulse_d;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/spc_switch_pwm_config_bank.sv ----
// Switch source, multipurpose pin, pulse channel and scratch register group
`timescale 1ns/10ps
`default_nettype none
module spc_switch_pwm_config_bank (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic soft_rst_i,
    input wire logic normal_mode_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [spc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [spc_pkg::DATA_W-1:0] wdata_i,
    input wire logic fault_three_i,
    input wire logic fault_four_i,
    input wire logic timer_one_i,
    input wire logic timer_two_i,
    input wire logic second_fail_output_i,
    input wire logic third_fail_output_i,
    input wire logic pin_one_in_i,
    input wire logic pin_two_in_i,
    output logic [spc_pkg::DATA_W-1:0] rdata_o,
    output logic switch_three_on_o,
    output logic switch_four_on_o,
    output logic timer_one_assigned_o,
    output logic timer_two_assigned_o,
    output logic [1:0] fail_output_duty_o,
    output logic pin_one_fail_o,
    output logic pin_two_fail_o,
    output logic pin_one_low_side_o,
    output logic pin_two_low_side_o,
    output logic pin_one_high_side_o,
    output logic pin_two_high_side_o,
    output logic pin_one_wake_o,
    output logic pin_two_wake_o,
    output logic pulse_one_o,
    output logic pulse_two_o
);
    import spc_pkg::*;

    logic [DATA_W-1:0] src_q, src_d, pin_q, pin_d, duty_one_q, duty_one_d;
    logic [DATA_W-1:0] duty_two_q, duty_two_d, freq_q, freq_d, scratch_q, scratch_d;
    logic [DATA_W-1:0] rdata_d;
    logic wr_src, wr_pin, wr_d1, wr_d2, wr_freq, wr_scr;

    assign wr_src = wr_en_i && (addr_i == ADDR_HIGH_SIDE_SOURCE_B);
    assign wr_pin = wr_en_i && (addr_i == ADDR_MULTIPURPOSE_PIN_CONFIG);
    assign wr_d1 = wr_en_i && (addr_i == ADDR_PULSE_DUTY_ONE);
    assign wr_d2 = wr_en_i && (addr_i == ADDR_PULSE_DUTY_TWO);
    assign wr_freq = wr_en_i && (addr_i == ADDR_PULSE_FREQUENCY_SELECT);
    assign wr_scr = wr_en_i && (addr_i == ADDR_HOST_SCRATCH_BYTE) && normal_mode_i;

    // Configuration registers
    always_comb begin
        src_d = src_q;
        pin_d = pin_q;
        duty_one_d = duty_one_q;
        duty_two_d = duty_two_q;
        freq_d = freq_q;
        if (en_i) begin
            if (soft_rst_i) begin
                src_d = RESET_VALUE;
                pin_d = RESET_VALUE;
                duty_one_d = RESET_VALUE;
                duty_two_d = RESET_VALUE;
                freq_d = RESET_VALUE;
            end else begin
                if (wr_src) begin
                    src_d = wdata_i & SOURCE_WRITE_MASK;
                end
                if (wr_pin) begin
                    pin_d = wdata_i;
                end
                if (wr_d1) begin
                    duty_one_d = wdata_i;
                end
                if (wr_d2) begin
                    duty_two_d = wdata_i;
                end
                if (wr_freq) begin
                    freq_d = wdata_i & FREQ_WRITE_MASK;
                end
                // Protection beats a same-cycle host write so a faulted switch stays off
                if (fault_three_i) begin
                    src_d[SRC_THREE_LSB +: SRC_W] = SRC_OFF;
                end
                if (fault_four_i) begin
                    src_d[SRC_FOUR_LSB +: SRC_W] = SRC_OFF;
                end
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            src_q <= RESET_VALUE;
            pin_q <= RESET_VALUE;
            duty_one_q <= RESET_VALUE;
            duty_two_q <= RESET_VALUE;
            freq_q <= RESET_VALUE;
        end else begin
            src_q <= src_d;
            pin_q <= pin_d;
            duty_one_q <= duty_one_d;
            duty_two_q <= duty_two_d;
            freq_q <= freq_d;
        end
    end

    // Scratch byte: power-on reset only, no internal reader
    always_comb begin
        scratch_d = scratch_q;
        if (en_i && wr_scr) begin
            scratch_d = wdata_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            scratch_q <= RESET_VALUE;
        end else begin
            scratch_q <= scratch_d;
        end
    end

    // Read data, registered; unmapped addresses read zero
    always_comb begin
        rdata_d = rdata_o;
        if (en_i && rd_en_i) begin
            case (addr_i)
                ADDR_HIGH_SIDE_SOURCE_B: rdata_d = src_q & SOURCE_WRITE_MASK;
                ADDR_MULTIPURPOSE_PIN_CONFIG: rdata_d = pin_q;
                ADDR_PULSE_DUTY_ONE: rdata_d = duty_one_q;
                ADDR_PULSE_DUTY_TWO: rdata_d = duty_two_q;
                ADDR_PULSE_FREQUENCY_SELECT: rdata_d = freq_q & FREQ_WRITE_MASK;
                ADDR_HOST_SCRATCH_BYTE: rdata_d = normal_mode_i ? scratch_q : RESET_VALUE;
                default: rdata_d = RESET_VALUE;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rdata_o <= RESET_VALUE;
        end else begin
            rdata_o <= rdata_d;
        end
    end

    // Pulse channels
    logic pulse_one_w, pulse_two_w;

    spc_pulse_channel u_pulse_one (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .en_i(en_i),
        .duty_i(duty_one_q),
        .fast_i(freq_q[FREQ_ONE_BIT]),
        .pulse_o(pulse_one_w)
    );

    spc_pulse_channel u_pulse_two (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .en_i(en_i),
        .duty_i(duty_two_q),
        .fast_i(freq_q[FREQ_TWO_BIT]),
        .pulse_o(pulse_two_w)
    );

    assign pulse_one_o = pulse_one_w;
    assign pulse_two_o = pulse_two_w;

    function automatic logic src_level(input logic [SRC_W-1:0] code, input logic t1, input logic t2,
                                       input logic p1, input logic p2);
        logic lvl;
        lvl = 1'b0;
        case (code)
            SRC_ON: lvl = 1'b1;
            SRC_TIMER_ONE: lvl = t1;
            SRC_TIMER_TWO: lvl = t2;
            SRC_PULSE_ONE: lvl = p1;
            SRC_PULSE_TWO: lvl = p2;
            default: lvl = 1'b0;
        endcase
        return lvl;
    endfunction

    // Switch drive and multipurpose pins
    logic [SRC_W-1:0] src3, src4, pin1, pin2;
    logic [WAKE_CNT_W-1:0] wcnt_q [2];
    logic [WAKE_CNT_W-1:0] wcnt_d [2];
    logic [1:0] wlvl_q, wlvl_d, pin_in, wake_en;
    logic sw3_d, sw4_d, t1a_d, t2a_d;
    logic [1:0] fduty_d;
    logic p1f_d, p2f_d, p1l_d, p2l_d, p1h_d, p2h_d, p1w_d, p2w_d;

    assign src3 = src_q[SRC_THREE_LSB +: SRC_W];
    assign src4 = src_q[SRC_FOUR_LSB +: SRC_W];
    assign pin1 = pin_q[PIN_ONE_LSB +: SRC_W];
    assign pin2 = pin_q[PIN_TWO_LSB +: SRC_W];
    assign pin_in = {pin_two_in_i, pin_one_in_i};
    assign wake_en = {pin2 == PIN_WAKE, pin1 == PIN_WAKE};

    always_comb begin
        sw3_d = switch_three_on_o;
        sw4_d = switch_four_on_o;
        t1a_d = timer_one_assigned_o;
        t2a_d = timer_two_assigned_o;
        fduty_d = fail_output_duty_o;
        p1f_d = pin_one_fail_o;
        p2f_d = pin_two_fail_o;
        p1l_d = pin_one_low_side_o;
        p2l_d = pin_two_low_side_o;
        p1h_d = pin_one_high_side_o;
        p2h_d = pin_two_high_side_o;
        p1w_d = pin_one_wake_o;
        p2w_d = pin_two_wake_o;
        wlvl_d = wlvl_q;
        wcnt_d = wcnt_q;
        if (en_i) begin
            sw3_d = src_level(src3, timer_one_i, timer_two_i, pulse_one_w, pulse_two_w);
            sw4_d = src_level(src4, timer_one_i, timer_two_i, pulse_one_w, pulse_two_w);
            // Timer block starts a timer only while some switch selects it
            t1a_d = (src3 == SRC_TIMER_ONE) || (src4 == SRC_TIMER_ONE);
            t2a_d = (src3 == SRC_TIMER_TWO) || (src4 == SRC_TIMER_TWO);
            fduty_d = pin_q[FAIL_DUTY_LSB +: 2];
            p1f_d = !pin1[2] && second_fail_output_i;
            p2f_d = !pin2[2] && third_fail_output_i;
            p1l_d = pin1 == PIN_LOW_SIDE;
            p2l_d = pin2 == PIN_LOW_SIDE;
            p1h_d = pin1 == PIN_HIGH_SIDE;
            p2h_d = pin2 == PIN_HIGH_SIDE;
            // Static filter: level taken only after it held for the full filter time
            for (int i = 0; i < 2; i++) begin
                if (!wake_en[i] || pin_in[i] == wlvl_q[i]) begin
                    wcnt_d[i] = '0;
                end else if (wcnt_q[i] >= WAKE_CNT_W'(WAKE_FILTER_CYC - 1)) begin
                    wcnt_d[i] = '0;
                    wlvl_d[i] = pin_in[i];
                end else begin
                    wcnt_d[i] = wcnt_q[i] + WAKE_CNT_W'(1);
                end
                if (!wake_en[i]) begin
                    wlvl_d[i] = 1'b0;
                end
            end
            p1w_d = wlvl_d[0];
            p2w_d = wlvl_d[1];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            switch_three_on_o <= 1'b0;
            switch_four_on_o <= 1'b0;
            timer_one_assigned_o <= 1'b0;
            timer_two_assigned_o <= 1'b0;
            fail_output_duty_o <= FAIL_DUTY_20;
            pin_one_fail_o <= 1'b0;
            pin_two_fail_o <= 1'b0;
            pin_one_low_side_o <= 1'b0;
            pin_two_low_side_o <= 1'b0;
            pin_one_high_side_o <= 1'b0;
            pin_two_high_side_o <= 1'b0;
            pin_one_wake_o <= 1'b0;
            pin_two_wake_o <= 1'b0;
            wlvl_q <= 2'h0;
            wcnt_q[0] <= '0;
            wcnt_q[1] <= '0;
        end else begin
            switch_three_on_o <= sw3_d;
            switch_four_on_o <= sw4_d;
            timer_one_assigned_o <= t1a_d;
            timer_two_assigned_o <= t2a_d;
            fail_output_duty_o <= fduty_d;
            pin_one_fail_o <= p1f_d;
            pin_two_fail_o <= p2f_d;
            pin_one_low_side_o <= p1l_d;
            pin_two_low_side_o <= p2l_d;
            pin_one_high_side_o <= p1h_d;
            pin_two_high_side_o <= p2h_d;
            pin_one_wake_o <= p1w_d;
            pin_two_wake_o <= p2w_d;
            wlvl_q <= wlvl_d;
            wcnt_q <= wcnt_d;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    AST_RSV_ZERO: assert property (en_i && rd_en_i && addr_i == ADDR_HIGH_SIDE_SOURCE_B
        |=> rdata_o[7] == 1'b0 && rdata_o[3] == 1'b0) else $error("reserved bits read nonzero");
    AST_FAULT_CLR: assert property (en_i && !soft_rst_i && fault_three_i
        |=> src_q[SRC_THREE_LSB +: SRC_W] == SRC_OFF ##1 !switch_three_on_o) else $error("fault did not clear source");
    AST_SRC_ON: assert property (en_i && src4 == SRC_ON |=> switch_four_on_o) else $error("on code not driven");
    AST_SRC_RSV: assert property (en_i && src3[2:1] == 2'b11 |=> !switch_three_on_o) else $error("reserved code drives");
    AST_SOFT_CLR: assert property (en_i && soft_rst_i
        |=> pin_q == RESET_VALUE && duty_one_q == RESET_VALUE && freq_q == RESET_VALUE) else $error("soft reset missed");
    AST_SCRATCH_KEEP: assert property (en_i && soft_rst_i && !wr_scr |=> $stable(scratch_q)) else $error("scratch lost");
    AST_SCRATCH_LOCK: assert property (!normal_mode_i |=> $stable(scratch_q)) else $error("scratch written outside normal");
    AST_DUTY_ZERO: assert property ($past(en_i) && $past(duty_one_q) == 8'h00 |-> !pulse_one_o) else $error("zero duty on");
    AST_DUTY_FULL: assert property ($past(en_i) && $past(duty_two_q) == 8'hff |-> pulse_two_o) else $error("full duty off");
    AST_PIN_ROUTE: assert property (en_i && !pin1[2] |=> pin_one_fail_o == $past(second_fail_output_i))
        else $error("fail output not routed");
    AST_PIN_HS: assert property (en_i && pin2 == PIN_HIGH_SIDE |=> pin_two_high_side_o && !pin_two_low_side_o)
        else $error("high side not on");
    COV_PULSE_ONE: cover property (!pulse_one_o ##1 pulse_one_o);
    COV_FAULT: cover property (switch_three_on_o ##1 fault_three_i);
    COV_WAKE: cover property (!pin_one_wake_o ##1 pin_one_wake_o);
endmodule
`default_nettype wire

// ---- sim/spc_host_model.sv ----
// Host model: byte writes and reads on the register strobe port
`timescale 1ns/10ps
`default_nettype none
module spc_host_model (
    input wire logic mclk_i,
    input wire logic [spc_pkg::DATA_W-1:0] rdata_i,
    output logic wr_en_o,
    output logic rd_en_o,
    output logic [spc_pkg::ADDR_W-1:0] addr_o,
    output logic [spc_pkg::DATA_W-1:0] wdata_o
);
    import spc_pkg::*;
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o = '0;
        wdata_o = '0;
    end
    // Released lines flip to the inverse so stale values never pass as valid
    task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_en_o <= 1'b1;
        @(posedge mclk_i);
        wr_en_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask
    task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge mclk_i);
        addr_o <= a;
        rd_en_o <= 1'b1;
        @(posedge mclk_i);
        rd_en_o <= 1'b0;
        addr_o <= ~a;
        @(posedge mclk_i);
        #1;
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

// ---- sim/test_spc_switch_pwm_config_bank.sv ----
// Self-checking bench for the switch source, pin and pulse register group
`timescale 1ns/10ps
`default_nettype none
module test_spc_switch_pwm_config_bank;
    import spc_pkg::*;
    localparam int PRE_SLOW = 10000000 / (200 * 255);
    logic mclk, rst_n, en, soft_rst, normal_mode, wr_en, rd_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic fault_three, fault_four, timer_one, timer_two, fail_two, fail_three, pin_one, pin_two;
    logic sw3, sw4, ta1, ta2, p1f, p2f, p1l, p2l, p1h, p2h, p1w, p2w, pu1, pu2, pv1, pv2;
    logic [1:0] fo_duty;
    int n_errors = 0;
    int check_count = 0;
    int seed = 32'h759f;
    int mdl [128];
    int i, j, d1, d2, hi1, hi2, up1, up2, xs;
    logic [6:0] regs [6] = '{7'h15, 7'h17, 7'h18, 7'h19, 7'h1c, 7'h1e};

    spc_host_model spc_host_model_inst (.mclk_i(mclk), .rdata_i(rdata), .wr_en_o(wr_en), .rd_en_o(rd_en),
        .addr_o(addr), .wdata_o(wdata));
    spc_switch_pwm_config_bank spc_switch_pwm_config_bank_inst (.mclk_i(mclk), .rst_n_i(rst_n), .en_i(en),
        .soft_rst_i(soft_rst), .normal_mode_i(normal_mode), .wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr),
        .wdata_i(wdata), .fault_three_i(fault_three), .fault_four_i(fault_four), .timer_one_i(timer_one),
        .timer_two_i(timer_two), .second_fail_output_i(fail_two), .third_fail_output_i(fail_three),
        .pin_one_in_i(pin_one), .pin_two_in_i(pin_two), .rdata_o(rdata), .switch_three_on_o(sw3),
        .switch_four_on_o(sw4), .timer_one_assigned_o(ta1), .timer_two_assigned_o(ta2),
        .fail_output_duty_o(fo_duty), .pin_one_fail_o(p1f), .pin_two_fail_o(p2f), .pin_one_low_side_o(p1l),
        .pin_two_low_side_o(p2l), .pin_one_high_side_o(p1h), .pin_two_high_side_o(p2h),
        .pin_one_wake_o(p1w), .pin_two_wake_o(p2w), .pulse_one_o(pu1), .pulse_two_o(pu2));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic conclude();
        if (n_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: value %h, model %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({7'h0, got}, {7'h0, exp});
    endtask
    task automatic chk_cnt(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            n_errors++;
            $display("unexpected at %0t: count %0d, model %0d", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] mask_of(input logic [6:0] a);
        case (a)
            7'h15: return 8'h77;
            7'h1c: return 8'h05;
            7'h17, 7'h18, 7'h19, 7'h1e: return 8'hff;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic src_level(input int code);
        case (code)
            1: return 1'b1;
            2: return timer_one;
            3: return timer_two;
            4: return mdl[7'h18] == 255;
            5: return mdl[7'h19] == 255;
            default: return 1'b0;
        endcase
    endfunction
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        spc_host_model_inst.write_reg(a, d);
        if (a != 7'h1e || normal_mode === 1'b1) mdl[a] = d & mask_of(a);
    endtask
    task automatic rd_chk(input logic [6:0] a);
        logic [7:0] v;
        spc_host_model_inst.read_reg(a, v);
        chk_val(v, (a == 7'h1e && normal_mode !== 1'b1) ? 8'h00 : 8'(mdl[a]));
    endtask
    task automatic settle();
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic all_rd();
        foreach (regs[k]) rd_chk(regs[k]);
    endtask

    initial begin
        // Long pulse window dominates; margin covers the register scenarios
        repeat (255 * PRE_SLOW + 5000) @(posedge mclk);
        n_errors++;
        $display("unexpected at %0t: run did not finish", $time);
        conclude();
    end

    initial begin
        {rst_n, soft_rst, fault_three, fault_four, timer_one, timer_two} <= '0;
        {fail_two, fail_three, pin_one, pin_two} <= '0;
        {en, normal_mode} <= 2'b11;
        for (i = 0; i < 128; i++) mdl[i] = 0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        all_rd();
        for (i = 0; i < 4; i++) begin
            foreach (regs[k]) begin
                wr(regs[k], 8'($random(seed)));
                rd_chk(regs[k]);
            end
        end
        wr(7'h16, 8'hff);
        rd_chk(7'h16);
        for (j = 0; j < 2; j++) begin
            wr(7'h18, (j == 0) ? 8'hff : 8'h00);
            wr(7'h19, (j == 0) ? 8'h00 : 8'hff);
            @(posedge mclk);
            timer_one <= (j == 0);
            timer_two <= (j != 0);
            for (i = 0; i < 8; i++) begin
                wr(7'h15, {1'b1, i[2:0], 1'b1, 3'(7 - i)});
                settle();
                chk_bit(sw3, src_level(7 - i));
                chk_bit(sw4, src_level(i));
                chk_bit(ta1, i == 2 || i == 5);
                chk_bit(ta2, i == 3 || i == 4);
            end
        end
        wr(7'h15, 8'h11);
        for (j = 0; j < 2; j++) begin
            @(posedge mclk);
            fault_three <= (j == 0);
            fault_four <= (j == 1);
            @(posedge mclk);
            {fault_three, fault_four} <= 2'b00;
            mdl[7'h15] = (j == 0) ? 8'h10 : 8'h00;
            settle();
            chk_bit(sw3, 1'b0);
            chk_bit(sw4, j == 0);
            rd_chk(7'h15);
        end
        for (i = 0; i < 8; i++) begin
            @(posedge mclk);
            fail_two <= i[0];
            fail_three <= ~i[0];
            wr(7'h17, {i[1:0], i[2:0], 3'(7 - i)});
            settle();
            chk_val({6'h0, fo_duty}, {6'h0, i[1:0]});
            chk_bit(p1f, (7 - i) < 4 && i[0]);
            chk_bit(p2f, i < 4 && !i[0]);
            chk_bit(p1l, i == 1);
            chk_bit(p2l, i == 6);
            chk_bit(p1h, i == 0);
            chk_bit(p2h, i == 7);
            chk_bit(p1w | p2w, 1'b0);
        end
        wr(7'h15, 8'h02);
        wr(7'h17, 8'h2d);
        @(posedge mclk);
        {pin_one, pin_two} <= 2'b11;
        repeat (100) @(posedge mclk);
        #1;
        chk_bit(p1w, 1'b0);
        @(posedge mclk);
        pin_two <= 1'b0;
        repeat (79) @(posedge mclk);
        #1;
        chk_bit(p1w, 1'b1);
        chk_bit(p2w, 1'b0);
        foreach (regs[k]) wr(regs[k], 8'($random(seed)));
        @(posedge mclk);
        soft_rst <= 1'b1;
        @(posedge mclk);
        soft_rst <= 1'b0;
        foreach (regs[k]) if (regs[k] != 7'h1e) mdl[regs[k]] = 0;
        all_rd();
        @(posedge mclk);
        normal_mode <= 1'b0;
        wr(7'h1e, 8'h5a);
        rd_chk(7'h1e);
        @(posedge mclk);
        normal_mode <= 1'b1;
        rd_chk(7'h1e);
        @(posedge mclk);
        en <= 1'b0;
        spc_host_model_inst.write_reg(7'h18, 8'h33);
        @(posedge mclk);
        en <= 1'b1;
        rd_chk(7'h18);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (regs[k]) mdl[regs[k]] = 0;
        all_rd();
        // Mid-range duties only; the smallest codes are not realisable on a switch
        d1 = 2 + (($random(seed) & 32'hff) % 253);
        d2 = 2 + (($random(seed) & 32'hff) % 253);
        wr(7'h18, 8'(d1));
        wr(7'h19, 8'(d2));
        wr(7'h1c, 8'h04);
        repeat (20) @(posedge mclk);
        #1;
        {hi1, hi2, up1, up2, xs} = '0;
        {pv1, pv2} = {pu1, pu2};
        // One slow period spans exactly two fast periods, so phase does not matter
        for (i = 0; i < 255 * PRE_SLOW; i++) begin
            @(posedge mclk);
            #1;
            // Integer sums turn unknowns into zero, so count them apart
            xs += $isunknown({pu1, pu2});
            hi1 += pu1;
            hi2 += pu2;
            up1 += (pu1 && !pv1);
            up2 += (pu2 && !pv2);
            {pv1, pv2} = {pu1, pu2};
        end
        chk_cnt(hi1, d1 * PRE_SLOW);
        chk_cnt(hi2, 2 * d2 * (PRE_SLOW / 2));
        chk_cnt(up1, 1);
        chk_cnt(up2, 2);
        chk_cnt(xs, 0);
        conclude();
    end
endmodule
`default_nettype wire
